// ===== include/shift_counter_map.svh
/*
  offsets-free constant map for the shift register counter family.
  assumes inclusion by bare name from the design.
*/
`ifndef SHIFT_COUNTER_MAP_SVH
`define SHIFT_COUNTER_MAP_SVH
`define SC_W4          4
`define SC_W7          7
`define SC_ALL1_4      4'hf
`define SC_ALL0_4      4'h0
`define SC_JUMP_FROM   4'h1
`define SC_JUMP_TO     4'h3
`define SC_LOAD_MASK7  7'h07
`define SC_DEC_LIMIT   4'h9
`define SC_PROG_MAX    7'h63
`endif

// ===== include/shift_counter_pkg.sv
/*
  types for the shift register counter family.
  assumes nothing beyond the map header.
*/
package shift_counter_pkg;
  typedef enum logic [6:0] {
    MODE_JOHNSON  = 7'h01,
    MODE_REVRING  = 7'h02,
    MODE_DECADE   = 7'h04,
    MODE_SIMPLE   = 7'h08,
    MODE_UPDOWN   = 7'h10,
    MODE_DIV4     = 7'h20,
    MODE_DIV7     = 7'h40
  } mode_t;
endpackage

// ===== hw/shift_counter.sv
/*
  shift register counter family: johnson ring, reversible ring, decade loop,
  simple feedback, up/down, divide-by-n 4/7 bit and two-decade program divider.
  assumes preset switches held stable around loads and mode chosen while idle.
*/
`timescale 1ns/1ps
`include "shift_counter_map.svh"
module shift_counter
  import shift_counter_pkg::*;
#(
  parameter int W = `SC_W7
)
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       master_clr,
  input  wire mode_t      mode,
  input  wire logic       count_up,
  input  wire logic [6:0] preset_sw,
  output logic [6:0]      stages,
  output logic            decode_hit,
  output logic            div_pulse
);
  // ****************************************
  // helpers
  // ****************************************
  // ring decode inverter plus and, active high
  function automatic logic ring_dec(input logic [3:0] q, input logic [1:0] k);
    logic [3:0] qx;
    qx = {q[0], q[3:1]};
    ring_dec = q[k] & ~qx[k];
  endfunction
  function automatic logic simple_fb(input logic first, input logic last);
    simple_fb = last ? first : ~first;
  endfunction
  // binary switch value split into tens and ones
  // values above 99 still divide by value plus one, up to 128
  function automatic logic [7:0] to_decades(input logic [6:0] v);
    logic [6:0] tens;
    logic [6:0] ones;
    tens       = v / 7'h0a;
    ones       = v - tens * 7'h0a;
    to_decades = {tens[3:0], ones[3:0]};
  endfunction

  logic [6:0] q_r;
  logic [6:0] q_nxt;
  logic [3:0] lo_dig_r;
  logic [3:0] hi_dig_r;
  logic       all1_hit;
  logic       load4;
  logic       load7;
  logic       fb;
  logic [6:0] q_upd;
  logic [7:0] dec_ld;

  assign all1_hit = (mode == MODE_DECADE) && (q_r[3:0] == `SC_ALL1_4);
  assign load4 = &q_r[2:0];
  assign load7 = &q_r[5:0];
  // all ones in decade mode clears the stages only, not the program divider
  // stages and decode always follow the register itself
  assign q_upd = (master_clr || all1_hit) ? 7'h00 : q_nxt;
  // reload value for the two decades
  assign dec_ld = to_decades(preset_sw);

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    fb    = 1'b0;
    q_nxt = q_r;
    case (mode)
      MODE_JOHNSON:
      begin
        // strays 2,5,a,4,6,9,b,d all drain into the loop
        fb    = ~q_r[3] & ~(q_r[2] & ~q_r[1]);
        q_nxt = {3'h0, q_r[2:0], fb};
      end
      MODE_REVRING:
      begin
        if (count_up)
          q_nxt = {4'h0, q_r[1:0], ~q_r[2] & ~(q_r[1] & ~q_r[0])};
        else
          q_nxt = {4'h0, ~q_r[0] & ~(q_r[1] & ~q_r[2]), q_r[2:1]};
      end
      MODE_DECADE:
      begin
        // second stage low with first stage high feeds a one, 0001 goes to 0011
        fb = simple_fb(q_r[0], q_r[3]) | (q_r[0] & ~q_r[1]);
        // zero on all ones, one on all zeros
        if (q_r[3:0] == `SC_ALL0_4)
          fb = 1'b1;
        else if (q_r[3:0] == `SC_ALL1_4)
          fb = 1'b0;
        // strays 2,5,a,4,9 fall back into the loop
        q_nxt = {3'h0, q_r[2:0], fb};
      end
      MODE_SIMPLE:
      begin
        fb    = simple_fb(q_r[0], q_r[3]);
        q_nxt = {3'h0, q_r[2:0], fb};
      end
      MODE_UPDOWN:
      begin
        // right shift up, left shift down
        if (count_up)
          q_nxt = {q_r[5:0], simple_fb(q_r[0], q_r[6])};
        else
          // exact inverse of the up step: zero in when first two stages differ
          q_nxt = {~(q_r[0] ^ q_r[1]), q_r[6:1]};
      end
      MODE_DIV4:
      begin
        if (load4)
          q_nxt = {3'h0, preset_sw[3:0]};
        else
          q_nxt = {3'h0, q_r[2:0], simple_fb(q_r[0], q_r[3])};
      end
      MODE_DIV7:
      begin
        if (load7)
          q_nxt = preset_sw;
        else
          q_nxt = {q_r[5:0], simple_fb(q_r[0], q_r[6])};
      end
      default:
        q_nxt = q_r;
    endcase
  end

  // ****************************************
  // stage register
  // ****************************************
  // common clock, master clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q_r <= 7'h00;
    else
      q_r <= q_upd;
  end

  // ****************************************
  // program divider, two decades counting down
  // ****************************************
  // divides by switch value plus one
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lo_dig_r <= 4'h0;
      hi_dig_r <= 4'h0;
    end
    else if (master_clr)
    begin
      lo_dig_r <= 4'h0;
      hi_dig_r <= 4'h0;
    end
    else if (lo_dig_r == 4'h0 && hi_dig_r == 4'h0)
    begin
      lo_dig_r <= dec_ld[3:0];
      hi_dig_r <= dec_ld[7:4];
    end
    else if (lo_dig_r == 4'h0)
    begin
      lo_dig_r <= `SC_DEC_LIMIT;
      hi_dig_r <= hi_dig_r - 4'h1;
    end
    else
      lo_dig_r <= lo_dig_r - 4'h1;
  end

  // ****************************************
  // outputs, all registered
  // ****************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stages     <= 7'h00;
      decode_hit <= 1'b0;
      div_pulse  <= 1'b0;
    end
    else
    begin
      stages     <= q_upd;
      // decode of state selected by sw
      decode_hit <= ring_dec(q_upd[3:0], preset_sw[1:0]);
      // one pulse per divider period; program divider in every mode but div4 and div7
      // a clear drops the pulse too, so no stale period end leaks past it
      div_pulse  <= master_clr ? 1'b0 :
                    (mode == MODE_DIV4) ? load4 :
                    (mode == MODE_DIV7) ? load7 :
                    (lo_dig_r == 4'h0 && hi_dig_r == 4'h0);
    end
  end
endmodule

// ===== dv/shift_counter_asserts.sv
/* port checker for shift_counter.
   assumes binding onto shift_counter, one clock domain. */
`timescale 1ns/1ps
module shift_counter_asserts
  import shift_counter_pkg::*;
#(
  parameter int W = 7
)
(
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       master_clr,
  input wire mode_t      mode,
  input wire logic       count_up,
  input wire logic [6:0] preset_sw,
  input wire logic [6:0] stages,
  input wire logic       decode_hit,
  input wire logic       div_pulse
);
  // ****
  // properties
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_clr_zeroes: assert property (master_clr |=> stages == 7'h00 && !div_pulse)
    else $error("clear missed");
  a_reset_clear: assert property ($rose(rst_n) |-> stages == 7'h00 && !div_pulse)
    else $error("reset state");
  a_ring_twist: assert property (!master_clr && mode == MODE_JOHNSON |=>
    stages[3:0] == {$past(stages[2:0]), ~$past(stages[3])}) else $error("ring step");
  a_simple_shift: assert property (!master_clr && mode == MODE_SIMPLE |=>
    stages[3:1] == $past(stages[2:0])) else $error("shift step");
  a_simple_feed: assert property (!master_clr && mode == MODE_SIMPLE |=>
    stages[0] == ($past(stages[0]) ~^ $past(stages[3]))) else $error("feedback");
  a_decade_cure: assert property (!master_clr && mode == MODE_DECADE &&
    stages[3:0] == 4'hf |=> stages == 7'h00) else $error("all ones held");
  a_div_load: assert property (!master_clr && mode == MODE_DIV4 &&
    stages[2:0] == 3'h7 |=> stages[3:0] == $past(preset_sw[3:0])) else $error("no load");
  a_div_shift: assert property (!master_clr && mode == MODE_DIV4 &&
    stages[2:0] != 3'h7 |=> stages[3:1] == $past(stages[2:0])) else $error("div shift");
endmodule
bind shift_counter shift_counter_asserts #(.W(W)) shift_counter_asserts_inst (.clk, .rst_n,
  .master_clr, .mode, .count_up, .preset_sw, .stages, .decode_hit, .div_pulse);

// ===== dv/switch_bank.sv
/* preset switches and a downstream pulse tally.
   assumes the bench moves set_val only away from loads. */
`timescale 1ns/1ps
module switch_bank (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [6:0]  set_val,
  input  wire logic        div_pulse,
  output logic [6:0]       preset_sw,
  output logic [15:0]      pulse_cnt
);
  always_ff @(posedge clk)
    preset_sw <= set_val;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      pulse_cnt <= 16'h0000;
    else
      pulse_cnt <= pulse_cnt + {15'h0000, div_pulse};
endmodule

// ===== dv/tb_top.sv
/* self-checking bench for shift_counter.
   assumes a 10 MHz clock and the switch model. */
`timescale 1ns/1ps
module tb_top;
  import shift_counter_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        master_clr = 1'b0;
  mode_t       mode = MODE_SIMPLE;
  logic        count_up = 1'b1;
  logic [6:0]  set_val = 7'h05;
  logic [6:0]  preset_sw;
  logic [6:0]  stages;
  logic        decode_hit;
  logic        div_pulse;
  logic [15:0] pulse_cnt;
  logic [6:0]  s;
  int          fails = 0;
  int          total_checks = 0;
  // ****
  // harness
  // ****
  shift_counter shift_counter_inst (.clk, .rst_n, .master_clr, .mode, .count_up,
    .preset_sw, .stages, .decode_hit, .div_pulse);
  switch_bank switch_bank_inst (.clk, .rst_n, .set_val, .div_pulse, .preset_sw, .pulse_cnt);
  initial
  begin
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [6:0] got, input logic [6:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic start(input mode_t m);
    @(posedge clk) mode <= m;
    master_clr <= 1'b1;
    @(posedge clk) master_clr <= 1'b0;
    #1;
  endtask
  task automatic walk(input mode_t m, input logic [63:0] seq, input int n);
    start(m);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk) #1;
      chk(stages, {3'h0, seq[4*i +: 4]});
    end
  endtask
  task automatic t_modes;
    for (int i = 0; i < 7; i++)
    begin
      count_up <= i[0];
      start(mode_t'(7'h01 << i));
      chk(stages, 7'h00);
      repeat (6) @(posedge clk);
    end
  endtask
  task automatic t_decade;
    start(MODE_DECADE);
    @(posedge clk) #1;
    s = stages;
    repeat (10) @(posedge clk);
    #1;
    chk(stages, s);
  endtask
  task automatic t_divide;
    logic [15:0] c0;
    start(MODE_DIV4);
    c0 = pulse_cnt;
    repeat (40) @(posedge clk);
    #1;
    chk({6'h00, pulse_cnt != 16'h0000}, 7'h01);
    // 12 states to the first load, then 9 per load for switches 0101
    chk(7'(pulse_cnt - c0), 7'h04);
  endtask
  task automatic t_decode;
    start(MODE_JOHNSON);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk) #1;
      chk({6'h00, decode_hit}, {6'h00, i == 1});
    end
  endtask
  task automatic t_updown;
    count_up <= 1'b1;
    start(MODE_UPDOWN);
    repeat (3) @(posedge clk);
    count_up <= 1'b0;
    #1;
    chk(stages, 7'h05);
    repeat (3) @(posedge clk);
    #1;
    chk(stages, 7'h00);
  endtask
  task automatic t_program;
    logic [15:0] c0;
    set_val <= 7'h0c;
    start(MODE_SIMPLE);
    c0 = pulse_cnt;
    repeat (35) @(posedge clk);
    #1;
    // switches at 12 give a 13-cycle period; the reload at 00 pulses at once
    chk(7'(pulse_cnt - c0), 7'h03);
  endtask
  task automatic t_cure;
    set_val <= 7'h0f;
    start(MODE_DIV4);
    repeat (12) @(posedge clk);
    mode <= MODE_DECADE;
    #1;
    chk(stages, 7'h0f);
    @(posedge clk) #1;
    chk(stages, 7'h00);
  endtask
  task conclude;
    $display("fails=%0d total_checks=%0d", fails, total_checks);
    if (fails == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_modes();
    walk(MODE_SIMPLE, 64'h008ce7bd6394a521, 15);
    walk(MODE_JOHNSON, 64'h08cef731, 8);
    walk(MODE_DECADE, 64'h08ce7bd631, 10);
    t_decade();
    t_divide();
    t_decode();
    t_updown();
    t_program();
    t_cure();
    conclude();
  end
  // a hang costs far more than the planned run of a few hundred cycles
  initial
  begin
    #200000;
    fails++;
    conclude();
  end
endmodule
